// >>> logic/trigger_route_select.sv
`timescale 1ns/100ps
module trigger_route_select
    import trig_route_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [ADDR_W-1:0]    s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [ADDR_W-1:0]    s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic [NUM_LINES-1:0] line_in,
    output logic [NUM_LINES-1:0]      line_out,
    output logic [NUM_LINES-1:0]      line_oe,
    input  wire logic                 ready_for_start,
    input  wire logic                 ready_for_advance,
    output logic                      advance_trig,
    output logic                      arm_ref_trig
);

    state_s q;
    state_s n;

    // register slots behind the byte offsets
    typedef enum {
        SLOT_NONE,
        SLOT_ADV_TYPE,
        SLOT_ADV_SRC,
        SLOT_ARM_TYPE,
        SLOT_ARM_SRC,
        SLOT_ADV_EXP,
        SLOT_RFS_EXP,
        SLOT_RFA_EXP,
        SLOT_SW_TRIG,
        SLOT_STATUS
    } slot_e;

    // shared by write and read paths so the two maps cannot drift apart
    function automatic slot_e slot_of(
        input logic [ADDR_W-1:0] a
    );
        slot_e s;
        s = SLOT_NONE;
        if (a == OFS_ADV_TYPE) begin
            s = SLOT_ADV_TYPE;
        end else if (a == OFS_ADV_SRC) begin
            s = SLOT_ADV_SRC;
        end else if (a == OFS_ARM_TYPE) begin
            s = SLOT_ARM_TYPE;
        end else if (a == OFS_ARM_SRC) begin
            s = SLOT_ARM_SRC;
        end else if (a == OFS_ADV_EXP) begin
            s = SLOT_ADV_EXP;
        end else if (a == OFS_RFS_EXP) begin
            s = SLOT_RFS_EXP;
        end else if (a == OFS_RFA_EXP) begin
            s = SLOT_RFA_EXP;
        end else if (a == OFS_SW_TRIG) begin
            s = SLOT_SW_TRIG;
        end else if (a == OFS_STATUS) begin
            s = SLOT_STATUS;
        end
        return s;
    endfunction : slot_of

    // one terminal out of the synchronised set
    function automatic logic term_pick(
        input logic [NUM_LINES-1:0] v,
        input logic [SEL_W-1:0]     sel
    );
        logic r;
        r = 1'b0;
        for (int i = 0; i < NUM_LINES; i++) begin
            if (sel == SEL_W'(i)) begin
                r = v[i];
            end
        end
        return r;
    endfunction : term_pick

    // one-hot line mask for an export selector, empty when off
    function automatic logic [NUM_LINES-1:0] export_mask(
        input logic [SEL_W-1:0] sel
    );
        logic [NUM_LINES-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_LINES; i++) begin
            if (sel == SEL_W'(i + 1)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : export_mask

    function automatic logic [31:0] apply_strb(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0]  strb
    );
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return r;
    endfunction : apply_strb

    assign s_axi_awready = !q.aw_hold && !q.bvalid;
    assign s_axi_wready  = !q.w_hold && !q.bvalid;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign line_out      = q.line_out;
    assign line_oe       = q.line_oe;
    assign advance_trig  = q.advance_trig;
    assign arm_ref_trig  = q.arm_ref_trig;

    always_comb begin
        logic                 aw_take;
        logic                 w_take;
        logic                 do_wr;
        logic [ADDR_W-1:0]    wa;
        logic [31:0]          wd;
        logic [3:0]           ws;
        logic                 sw_adv;
        logic                 sw_arm;
        logic                 clr_arm;
        logic                 clr_adv;
        logic [NUM_LINES-1:0] rise;
        logic                 adv_fire;
        logic                 arm_fire;
        logic [NUM_LINES-1:0] m_adv;
        logic [NUM_LINES-1:0] m_rfs;
        logic [NUM_LINES-1:0] m_rfa;
        logic [31:0]          rd;
        logic [1:0]           rr;
        aw_take  = s_axi_awvalid && s_axi_awready;
        w_take   = s_axi_wvalid && s_axi_wready;
        do_wr    = (q.aw_hold || aw_take) && (q.w_hold || w_take)
                   && !q.bvalid;
        wa       = q.aw_hold ? q.awaddr : s_axi_awaddr;
        wd       = q.w_hold ? q.wdata : s_axi_wdata;
        ws       = q.w_hold ? q.wstrb : s_axi_wstrb;
        sw_adv   = 1'b0;
        sw_arm   = 1'b0;
        clr_arm  = 1'b0;
        clr_adv  = 1'b0;
        rise     = '0;
        adv_fire = 1'b0;
        arm_fire = 1'b0;
        m_adv    = '0;
        m_rfs    = '0;
        m_rfa    = '0;
        rd       = '0;
        rr       = RESP_OKAY;
        n        = q;

        // three-stage synchroniser; a level counts once stages 2 and 3 agree
        n.sync1 = line_in;
        n.sync2 = q.sync1;
        n.sync3 = q.sync2;
        n.filt  = (q.sync2 & q.sync3) | (q.filt & (q.sync2 | q.sync3));
        rise    = q.sync2 & q.sync3 & ~q.filt;

        // write channel: address and data taken in either order
        if (aw_take) begin
            n.aw_hold = 1'b1;
            n.awaddr  = s_axi_awaddr;
        end
        if (w_take) begin
            n.w_hold = 1'b1;
            n.wdata  = s_axi_wdata;
            n.wstrb  = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (do_wr) begin
            n.aw_hold = 1'b0;
            n.w_hold  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = RESP_OKAY;
            case (slot_of(wa))
                SLOT_ADV_TYPE: begin
                    n.adv_type = TYPE_W'(apply_strb(32'(q.adv_type), wd, ws));
                end
                SLOT_ADV_SRC: begin
                    n.adv_src = SEL_W'(apply_strb(32'(q.adv_src), wd, ws));
                end
                SLOT_ARM_TYPE: begin
                    n.arm_type = TYPE_W'(apply_strb(32'(q.arm_type), wd, ws));
                end
                SLOT_ARM_SRC: begin
                    n.arm_src = SEL_W'(apply_strb(32'(q.arm_src), wd, ws));
                end
                SLOT_ADV_EXP: begin
                    n.adv_exp = SEL_W'(apply_strb(32'(q.adv_exp), wd, ws));
                end
                SLOT_RFS_EXP: begin
                    n.rfs_exp = SEL_W'(apply_strb(32'(q.rfs_exp), wd, ws));
                end
                SLOT_RFA_EXP: begin
                    n.rfa_exp = SEL_W'(apply_strb(32'(q.rfa_exp), wd, ws));
                end
                SLOT_SW_TRIG: begin
                    sw_adv = ws[0] && wd[SW_ADV_BIT];
                    sw_arm = ws[0] && wd[SW_ARM_BIT];
                end
                SLOT_STATUS: begin
                    clr_arm = ws[0] && wd[ST_ARM_BIT];
                    clr_adv = ws[0] && wd[ST_ADV_BIT];
                end
                default: begin
                    n.bresp = RESP_SLVERR;
                end
            endcase
        end

        // advance trigger; unknown type codes behave as none
        case (q.adv_type)
            TYPE_DIGITAL_EDGE: begin
                // source consulted only in this type
                adv_fire = (q.adv_src <= TERM_LAST)
                           && term_pick(rise, q.adv_src);
            end
            TYPE_SOFTWARE: begin
                adv_fire = sw_adv;
            end
            default: begin
                adv_fire = 1'b0;
            end
        endcase

        case (q.arm_type)
            TYPE_DIGITAL_EDGE: begin
                arm_fire = (q.arm_src <= TERM_LAST)
                           && term_pick(rise, q.arm_src);
            end
            TYPE_SOFTWARE: begin
                arm_fire = sw_arm;
            end
            default: begin
                arm_fire = 1'b0;
            end
        endcase

        n.advance_trig = adv_fire;
        n.arm_ref_trig = arm_fire;
        // sticky flags: a new trigger beats a clear in the same cycle
        n.arm_seen = arm_fire || (q.arm_seen && !clr_arm);
        n.adv_seen = adv_fire || (q.adv_seen && !clr_adv);

        // export routing; idle selected lines are driven low
        m_adv = export_mask(q.adv_exp);
        m_rfs = export_mask(q.rfs_exp);
        m_rfa = export_mask(q.rfa_exp);
        n.line_oe  = m_adv | m_rfs | m_rfa;
        n.line_out = (m_adv & {NUM_LINES{adv_fire}})
                   | (m_rfs & {NUM_LINES{ready_for_start}})
                   | (m_rfa & {NUM_LINES{ready_for_advance}});

        // read channel
        if (q.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            case (slot_of(s_axi_araddr))
                SLOT_ADV_TYPE: begin
                    rd = 32'(q.adv_type);
                end
                SLOT_ADV_SRC: begin
                    rd = 32'(q.adv_src);
                end
                SLOT_ARM_TYPE: begin
                    rd = 32'(q.arm_type);
                end
                SLOT_ARM_SRC: begin
                    rd = 32'(q.arm_src);
                end
                SLOT_ADV_EXP: begin
                    rd = 32'(q.adv_exp);
                end
                SLOT_RFS_EXP: begin
                    rd = 32'(q.rfs_exp);
                end
                SLOT_RFA_EXP: begin
                    rd = 32'(q.rfa_exp);
                end
                SLOT_SW_TRIG: begin
                    rd = '0;
                end
                SLOT_STATUS: begin
                    rd[ST_ARM_BIT] = q.arm_seen;
                    rd[ST_ADV_BIT] = q.adv_seen;
                    rd[ST_LINES_LSB +: NUM_LINES] = q.filt;
                end
                default: begin
                    rr = RESP_SLVERR;
                end
            endcase
            n.rvalid = 1'b1;
            n.rdata  = rd;
            n.rresp  = rr;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q.sync1        <= '0;
            q.sync2        <= '0;
            q.sync3        <= '0;
            q.filt         <= '0;
            q.adv_type     <= TYPE_NONE;
            q.arm_type     <= TYPE_NONE;
            q.adv_src      <= '0;
            q.arm_src      <= '0;
            q.adv_exp      <= EXPORT_OFF;
            q.rfs_exp      <= EXPORT_OFF;
            q.rfa_exp      <= EXPORT_OFF;
            q.advance_trig <= 1'b0;
            q.arm_ref_trig <= 1'b0;
            q.arm_seen     <= 1'b0;
            q.adv_seen     <= 1'b0;
            q.line_out     <= '0;
            q.line_oe      <= '0;
            q.aw_hold      <= 1'b0;
            q.awaddr       <= '0;
            q.w_hold       <= 1'b0;
            q.wdata        <= '0;
            q.wstrb        <= '0;
            q.bvalid       <= 1'b0;
            q.bresp        <= RESP_OKAY;
            q.rvalid       <= 1'b0;
            q.rdata        <= '0;
            q.rresp        <= RESP_OKAY;
        end else begin
            q <= n;
        end
    end

endmodule : trigger_route_select

// >>> logic/trig_route_pkg.sv
package trig_route_pkg;

    localparam int NUM_LINES = 11;
    localparam int ADDR_W    = 8;
    localparam int TYPE_W    = 10;
    localparam int SEL_W     = 4;

    // trigger type codes
    localparam logic [TYPE_W-1:0] TYPE_NONE         = 10'd600;
    localparam logic [TYPE_W-1:0] TYPE_DIGITAL_EDGE = 10'd601;
    localparam logic [TYPE_W-1:0] TYPE_SOFTWARE     = 10'd604;

    // terminal codes: 0 func_line_0, 1 func_line_1, 2..9 backplane 0..7,
    // 10 star; export codes are terminal code plus one, 0 is export_off
    localparam logic [SEL_W-1:0] TERM_LAST  = 4'ha;
    localparam logic [SEL_W-1:0] EXPORT_OFF = 4'h0;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_ADV_TYPE = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_ADV_SRC  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_ARM_TYPE = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_ARM_SRC  = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_ADV_EXP  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_RFS_EXP  = 8'h14;
    localparam logic [ADDR_W-1:0] OFS_RFA_EXP  = 8'h18;
    localparam logic [ADDR_W-1:0] OFS_SW_TRIG  = 8'h1c;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h20;

    // field positions
    localparam int SW_ADV_BIT    = 0;
    localparam int SW_ARM_BIT    = 1;
    localparam int ST_ARM_BIT    = 0;
    localparam int ST_ADV_BIT    = 1;
    localparam int ST_LINES_LSB  = 16;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [NUM_LINES-1:0] sync1;
        logic [NUM_LINES-1:0] sync2;
        logic [NUM_LINES-1:0] sync3;
        logic [NUM_LINES-1:0] filt;
        logic [TYPE_W-1:0]    adv_type;
        logic [TYPE_W-1:0]    arm_type;
        logic [SEL_W-1:0]     adv_src;
        logic [SEL_W-1:0]     arm_src;
        logic [SEL_W-1:0]     adv_exp;
        logic [SEL_W-1:0]     rfs_exp;
        logic [SEL_W-1:0]     rfa_exp;
        logic                 advance_trig;
        logic                 arm_ref_trig;
        logic                 arm_seen;
        logic                 adv_seen;
        logic [NUM_LINES-1:0] line_out;
        logic [NUM_LINES-1:0] line_oe;
        logic                 aw_hold;
        logic [ADDR_W-1:0]    awaddr;
        logic                 w_hold;
        logic [31:0]          wdata;
        logic [3:0]           wstrb;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
    } state_s;

endpackage : trig_route_pkg

// >>> verif/trig_partner.sv
`timescale 1ns/100ps
module trig_partner
    import trig_route_pkg::*;
(
    input  wire logic [NUM_LINES-1:0] line_out,
    input  wire logic [NUM_LINES-1:0] line_oe,
    input  wire logic [NUM_LINES-1:0] other_drv,
    output logic [NUM_LINES-1:0]      line_in
);
    // other instruments pull high; lines nobody drives sit on a pull-down
    assign line_in = (line_oe & line_out) | (~line_oe & other_drv);
endmodule : trig_partner

// >>> verif/trigger_route_select_assertions.sv
`timescale 1ns/100ps
module trigger_route_select_assertions (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        advance_trig,
    input wire logic        arm_ref_trig
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    property p_wr_resp;
        s_wr_taken |=> s_axi_bvalid;
    endproperty
    property p_b_hold;
        s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_b_block;
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
    endproperty
    property p_rd_resp;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    property p_r_drop;
        s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
    endproperty
    property p_adv_pulse;
        $rose(advance_trig) |=> !advance_trig;
    endproperty
    property p_arm_pulse;
        arm_ref_trig |=> !arm_ref_trig;
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("no write response");
    a_b_hold: assert property (p_b_hold) else $error("write response lost");
    a_b_block: assert property (p_b_block) else $error("write taken early");
    a_rd_resp: assert property (p_rd_resp) else $error("no read response");
    a_r_hold: assert property (p_r_hold) else $error("read data lost");
    a_r_drop: assert property (p_r_drop) else $error("read not closed");
    a_adv_pulse: assert property (p_adv_pulse)
        else $error("advance pulse too long");
    a_arm_pulse: assert property (p_arm_pulse)
        else $error("arm pulse too long");
endmodule : trigger_route_select_assertions
bind trigger_route_select trigger_route_select_assertions chk_u (.*);

// >>> verif/trigger_route_select_bench.sv
`timescale 1ns/100ps
module trigger_route_select_bench
    import trig_route_pkg::*;
;
    logic                 clk = 1'b0, rst_n = 1'b0;
    logic [ADDR_W-1:0]    s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0]          s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]           s_axi_wstrb = 4'hf;
    logic                 s_axi_awvalid = 0, s_axi_wvalid = 0;
    logic                 s_axi_bready = 0, s_axi_arvalid = 0;
    logic                 s_axi_rready = 0, ready_for_start = 0;
    logic                 ready_for_advance = 0;
    logic                 s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic                 s_axi_arready, s_axi_rvalid;
    logic                 advance_trig, arm_ref_trig;
    logic [1:0]           s_axi_bresp, s_axi_rresp;
    logic [NUM_LINES-1:0] line_in, line_out, line_oe, other_drv = '0;
    int                   bad_count = 0, tests_run = 0;
    logic [31:0]          adv_n = '0, arm_n = '0, ln_n = '0;
    logic [31:0]          adv_b = '0, arm_b = '0, ln_b = '0;
    int                   dst = 0;
    trigger_route_select dut_u (.*);
    trig_partner peer_u (.line_out(line_out), .line_oe(line_oe),
        .other_drv(other_drv), .line_in(line_in));
    initial begin
        forever #20 clk = ~clk;
    end
    // pulse widths are judged by counting high cycles; an unknown sticks
    always @(posedge clk) begin
        if (rst_n) begin
            adv_n <= adv_n + advance_trig;
            arm_n <= arm_n + arm_ref_trig;
            ln_n <= ln_n + (line_out[dst] & line_oe[dst]);
        end
    end
    task cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : cmp
    task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ta, tw, tb;
        tb = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!tb) begin
            @(negedge clk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
        end
        // late bready makes the response wait one cycle
        s_axi_bready <= 1'b1;
        @(posedge clk);
        cmp("bresp", er, s_axi_bresp);
        s_axi_bready <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        logic ta, tr;
        tr = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!tr) begin
            @(negedge clk);
            ta = s_axi_arready;
            tr = s_axi_rvalid;
            @(posedge clk);
            if (ta) s_axi_arvalid <= 1'b0;
        end
        // late rready makes the data wait one cycle
        s_axi_rready <= 1'b1;
        @(posedge clk);
        cmp("rdata", e, s_axi_rdata);
        cmp("rresp", er, s_axi_rresp);
        s_axi_rready <= 1'b0;
    endtask : rd
    task chk(input int ea, input int er);
        repeat (6) @(posedge clk);
        @(negedge clk);
        cmp("advance pulses", ea, adv_n - adv_b);
        cmp("arm pulses", er, arm_n - arm_b);
        cmp("export line", ea, ln_n - ln_b);
        adv_b = adv_n;
        arm_b = arm_n;
        ln_b = ln_n;
    endtask : chk
    task fire(input int t, input int ea, input int er);
        @(posedge clk);
        other_drv[t] <= 1'b1;
        repeat (6) @(posedge clk);
        other_drv[t] <= 1'b0;
        chk(ea, er);
    endtask : fire
    task sw(input logic [31:0] bits, input int ea, input int er);
        wr(OFS_SW_TRIG, bits, RESP_OKAY);
        chk(ea, er);
    endtask : sw
    task ev(input logic s, input int d, input int e);
        dst = d;
        ln_b = ln_n;
        @(posedge clk);
        if (s) ready_for_start <= 1'b1;
        else ready_for_advance <= 1'b1;
        @(posedge clk);
        ready_for_start <= 1'b0;
        ready_for_advance <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        cmp("export line", e, ln_n - ln_b);
        ln_b = ln_n;
    endtask : ev
    task end_of_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    initial begin
        #400000;
        bad_count++;
        end_of_test;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_ADV_TYPE, TYPE_NONE, RESP_OKAY);
        rd(OFS_ARM_TYPE, TYPE_NONE, RESP_OKAY);
        rd(8'h40, 32'h0, RESP_SLVERR);
        wr(8'h40, 32'h1, RESP_SLVERR);
        cmp("line_oe", 0, line_oe);
        $display("test reset done");
        wr(OFS_ADV_TYPE, TYPE_DIGITAL_EDGE, RESP_OKAY);
        for (int t = 0; t <= TERM_LAST; t++) begin
            dst = (t + 1) % NUM_LINES;
            wr(OFS_ADV_SRC, t, RESP_OKAY);
            wr(OFS_ADV_EXP, dst + 1, RESP_OKAY);
            @(negedge clk);
            cmp("line_oe", 1 << dst, line_oe);
            fire((t + 6) % NUM_LINES, 0, 0);
            fire(t, 1, 0);
        end
        $display("test advance edge done");
        wr(OFS_ADV_TYPE, TYPE_SOFTWARE, RESP_OKAY);
        fire(TERM_LAST, 0, 0);
        sw(32'h1, 1, 0);
        sw(32'h2, 0, 0);
        wr(OFS_ADV_TYPE, TYPE_NONE, RESP_OKAY);
        sw(32'h1, 0, 0);
        fire(TERM_LAST, 0, 0);
        @(posedge clk);
        s_axi_wstrb <= 4'h1;
        // low byte only turns 600 into 601
        wr(OFS_ADV_TYPE, 32'h59, RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        fire(TERM_LAST, 1, 0);
        $display("test advance type done");
        wr(OFS_ADV_TYPE, TYPE_NONE, RESP_OKAY);
        wr(OFS_ARM_TYPE, TYPE_DIGITAL_EDGE, RESP_OKAY);
        wr(OFS_ARM_SRC, 32'h4, RESP_OKAY);
        fire(5, 0, 0);
        fire(4, 0, 1);
        // an unlisted type code acts as none
        wr(OFS_ARM_TYPE, 32'h25a, RESP_OKAY);
        fire(4, 0, 0);
        wr(OFS_ARM_TYPE, TYPE_DIGITAL_EDGE, RESP_OKAY);
        sw(32'h2, 0, 0);
        wr(OFS_ARM_TYPE, TYPE_SOFTWARE, RESP_OKAY);
        fire(4, 0, 0);
        sw(32'h3, 0, 1);
        rd(OFS_STATUS, 32'h3, RESP_OKAY);
        wr(OFS_STATUS, 32'h3, RESP_OKAY);
        rd(OFS_STATUS, 32'h0, RESP_OKAY);
        $display("test arm reference done");
        wr(OFS_ADV_EXP, EXPORT_OFF, RESP_OKAY);
        wr(OFS_RFS_EXP, 32'h3, RESP_OKAY);
        wr(OFS_RFA_EXP, 32'hb, RESP_OKAY);
        @(negedge clk);
        cmp("line_oe", 32'h404, line_oe);
        ev(1'b1, 2, 1);
        ev(1'b0, 10, 1);
        ev(1'b0, 2, 0);
        wr(OFS_RFS_EXP, EXPORT_OFF, RESP_OKAY);
        wr(OFS_RFA_EXP, EXPORT_OFF, RESP_OKAY);
        ev(1'b1, 2, 0);
        cmp("line_oe", 0, line_oe);
        $display("test export done");
        end_of_test;
    end
endmodule : trigger_route_select_bench
